// File: bench/ldpt_timer_bench.sv
// Self-checking bench for the long duration periodic timer
`timescale 1ns/10ps
module ldpt_timer_bench;
	import ldpt_pkg::*;
	logic        clk, rst, por, fast_source_clock, slow_source_clock, irq;
	ldpt_req_s   req;
	logic [7:0]  rdata;
	logic [31:0] count_value;
	int          num_errors, total_checks;
	ldpt_timer u_dut (.clk(clk), .rst(rst), .por(por), .fast_source_clock(fast_source_clock),
		.slow_source_clock(slow_source_clock), .req(req), .rdata(rdata), .irq(irq), .count_value(count_value));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		req = '{1'b0, 1'b1, a, d};
		@(negedge clk);
		req.wr = 1'b0;
		@(negedge clk);
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		req = '{1'b1, 1'b0, a, 8'h00};
		@(negedge clk);
		req.rd = 1'b0;
		d = rdata;
		@(negedge clk);
	endtask
	task automatic wr32(input logic [31:0] v);
		for (int i = 0; i < 4; i++)
			wr(3'(i), v[8*i +: 8]);
	endtask
	// Slow or fast pin edges, each level held three cycles
	task automatic pulse(input logic f, input int n);
		repeat (n)
		begin
			{fast_source_clock, slow_source_clock} = f ? 2'b10 : 2'b01;
			repeat (3) @(negedge clk);
			{fast_source_clock, slow_source_clock} = 2'b00;
			repeat (3) @(negedge clk);
		end
	endtask
	task automatic t_regs();
		logic [7:0] b;
		rd(LDPT_ADDR_CTRL, b);
		chk("ctrl", 32'h00, b);
		wr(LDPT_ADDR_CTRL, 8'hff);
		rd(LDPT_ADDR_CTRL, b);
		chk("ctrl", 32'h2f, b);
		rd(3'h5, b);
		chk("unmapped", 32'h00, b);
		wr(LDPT_ADDR_CTRL, 8'h00);
		$display("regs done");
	endtask
	task automatic t_bytes();
		logic [7:0] b [4];
		wr32(32'h44332211);
		for (int i = 0; i < 4; i++)
			rd(3'(i), b[i]);
		chk("count", 32'h44332211, {b[3], b[2], b[1], b[0]});
		wr(LDPT_ADDR_BYTE1, 8'haa);
		rd(LDPT_ADDR_BYTE0, b[0]);
		wr(LDPT_ADDR_BYTE1, 8'h55);
		rd(LDPT_ADDR_BYTE1, b[1]);
		chk("snapshot", 32'haa, b[1]);
		chk("live", 32'h44335511, count_value);
		rst = 1'b1;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk("kept", 32'h44335511, count_value);
		$display("bytes done");
	endtask
	task automatic t_wrap();
		logic [7:0] b;
		wr32(32'hfffffffe);
		wr(LDPT_ADDR_CTRL, 8'h21);
		pulse(1'b0, 1);
		chk("irq", 32'h0, irq);
		pulse(1'b0, 1);
		chk("wrap", 32'h0, count_value);
		chk("irq", 32'h1, irq);
		rd(LDPT_ADDR_CTRL, b);
		wr(LDPT_ADDR_CTRL, b & 8'hef);
		chk("irq", 32'h0, irq);
		wr(LDPT_ADDR_CTRL, 8'h00);
		pulse(1'b0, 2);
		chk("halt", 32'h0, count_value);
		wr(LDPT_ADDR_CTRL, 8'h01);
		pulse(1'b1, 8);
		pulse(1'b0, 2);
		chk("fast", 32'h2, count_value);
		wr(LDPT_ADDR_CTRL, 8'h00);
		$display("wrap done");
	endtask
	task automatic t_modes();
		logic [31:0] term [7] = '{32'h270f, 32'h1387, 32'h7cf, 32'h3e7, 32'h1f3, 32'hc7, 32'h63};
		for (int m = 1; m < 8; m++)
		begin
			wr32(term[m-1] - 32'h1);
			wr(LDPT_ADDR_CTRL, {4'b0010, 3'(m), 1'b1});
			pulse(1'b0, 1);
			chk("terminal", term[m-1], count_value);
			pulse(1'b0, 1);
			chk("restart", 32'h0, count_value);
			chk("tick", 32'h1, irq);
			wr(LDPT_ADDR_CTRL, 8'h10);
			chk("tick", 32'h1, irq);
			wr(LDPT_ADDR_CTRL, 8'h00);
		end
		$display("modes done");
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		{rst, por, fast_source_clock, slow_source_clock} = 4'hc;
		req = '0;
		repeat (3) @(negedge clk);
		{rst, por} = 2'h0;
		t_regs();
		t_bytes();
		t_wrap();
		t_modes();
		give_verdict();
	end
endmodule

// File: bench/ldpt_timer_properties.sv
// Port-level checks for the long duration periodic timer
`timescale 1ns/10ps
module ldpt_timer_properties
import ldpt_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        por,
	input wire ldpt_req_s   req,
	input wire logic [7:0]  rdata,
	input wire logic        irq,
	input wire logic [31:0] count_value
);
	import ldpt_pkg::*;
	logic run_t;
	wire  cw = req.wr && req.addr == LDPT_ADDR_CTRL;
	// Run bit as last written by software
	always_ff @(posedge clk or posedge rst)
		if (rst)
			run_t <= 1'b0;
		else if (cw)
			run_t <= req.wdata[LDPT_BIT_RUN];
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst || por);
	sequence s_idle;
		!run_t && !req.wr;
	endsequence
	sequence s_held;
		rst ##1 rst;
	endsequence
	low_snap_a: assert property (req.rd && req.addr == LDPT_ADDR_BYTE0 |=> rdata == count_value[7:0])
		else $error("low byte read not live count");
	rdata_hold_a: assert property (!req.rd |=> $stable(rdata))
		else $error("read data moved");
	unmapped_read_a: assert property (req.rd && req.addr > LDPT_ADDR_CTRL |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	wrap_flag_a: assert property ($rose(irq) |-> ##[0:2] count_value == LDPT_COUNT_ZERO)
		else $error("flag without wrap");
	stop_flag_a: assert property (!run_t |=> !$rose(irq))
		else $error("flag while halted");
	flag_clear_a: assert property (cw && !req.wdata[LDPT_BIT_FLAG] && !run_t |=> !irq)
		else $error("flag not cleared");
	flag_keep_a: assert property (irq && !cw |=> irq)
		else $error("flag dropped");
	halt_hold_a: assert property (s_idle [*3] |=> $stable(count_value))
		else $error("count moved while halted");
	byte_load_a: assert property (req.wr && req.addr == LDPT_ADDR_BYTE0 && !run_t |=> ##1
		count_value[7:0] == $past(req.wdata, 2) && count_value[31:8] == $past(count_value[31:8]))
		else $error("byte load wrong");
	rst_keep_a: assert property (disable iff (por) s_held |=> $stable(count_value))
		else $error("count lost on reset");
endmodule
bind ldpt_timer ldpt_timer_properties u_props (.clk(clk), .rst(rst), .por(por), .req(req),
	.rdata(rdata), .irq(irq), .count_value(count_value));

// File: inc/ldpt_pkg.sv
// Register map, field layout and timing constants for the long duration periodic timer
package ldpt_pkg;

	localparam logic [2:0] LDPT_ADDR_BYTE0 = 3'h0;
	localparam logic [2:0] LDPT_ADDR_BYTE1 = 3'h1;
	localparam logic [2:0] LDPT_ADDR_BYTE2 = 3'h2;
	localparam logic [2:0] LDPT_ADDR_BYTE3 = 3'h3;
	localparam logic [2:0] LDPT_ADDR_CTRL  = 3'h4;

	localparam int LDPT_BIT_RUN  = 0;
	localparam int LDPT_BIT_MODE = 1;
	localparam int LDPT_BIT_FLAG = 4;
	localparam int LDPT_BIT_CSEL = 5;

	localparam logic [31:0] LDPT_COUNT_ZERO = 32'h0000_0000;
	localparam logic [31:0] LDPT_COUNT_ONE  = 32'h0000_0001;
	localparam logic [31:0] LDPT_COUNT_MAX  = 32'hffff_ffff;
	localparam logic [2:0]  LDPT_MODE_ZERO  = 3'h0;
	localparam logic [7:0]  LDPT_BYTE_ZERO  = 8'h00;

	// Fast source clock is divided by this before counting
	localparam int          LDPT_FAST_DIV   = 4;
	localparam logic [1:0]  LDPT_DIV_LAST   = 2'(LDPT_FAST_DIV - 1);
	localparam logic [1:0]  LDPT_DIV_ZERO   = 2'h0;

	// Count clock reference for the periodic rates, in Hz
	localparam int LDPT_REF_HZ = 1000000;

	typedef enum logic [2:0]
	{
		LDPT_ELAPSED   = 3'b000,
		LDPT_TICK_100  = 3'b001,
		LDPT_TICK_200  = 3'b010,
		LDPT_TICK_500  = 3'b011,
		LDPT_TICK_1K   = 3'b100,
		LDPT_TICK_2K   = 3'b101,
		LDPT_TICK_5K   = 3'b110,
		LDPT_TICK_10K  = 3'b111
	} ldpt_mode_e;

	// Byte-wide register port request
	typedef struct packed
	{
		logic       rd;
		logic       wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} ldpt_req_s;

	// Control fields held by the block
	typedef struct packed
	{
		logic       csel;
		logic       flag;
		ldpt_mode_e mode;
		logic       run;
	} ldpt_ctrl_s;

endpackage

// File: rtl/ldpt_prediv.sv
// Divide-by-four enable for the fast source clock edges
`timescale 1ns/10ps
module ldpt_prediv
import ldpt_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic edge_in,
	output logic      tick
);
	logic [1:0] phase;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			phase <= LDPT_DIV_ZERO;
		else if (edge_in)
			phase <= (phase == LDPT_DIV_LAST) ? LDPT_DIV_ZERO : 2'(phase + 2'h1);
	end

	assign tick = edge_in & (phase == LDPT_DIV_LAST);
endmodule

// File: rtl/ldpt_sync.sv
// Two-flop synchroniser with rising edge pulse for an external clock pin
`timescale 1ns/10ps
module ldpt_sync
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pin,
	output logic      rise
);
	logic meta;
	logic stable;
	logic prev;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta   <= 1'b0;
			stable <= 1'b0;
			prev   <= 1'b0;
		end
		else
		begin
			meta   <= pin;
			stable <= meta;
			prev   <= stable;
		end
	end

	assign rise = stable & ~prev;
endmodule

// File: rtl/ldpt_timer.sv
// Long duration periodic timer: 32-bit count, snapshot, byte register port
`timescale 1ns/10ps
module ldpt_timer
import ldpt_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        por,
	input  wire logic        fast_source_clock,
	input  wire logic        slow_source_clock,
	input  wire ldpt_req_s   req,
	output logic [7:0]       rdata,
	output logic             irq,
	output logic [31:0]      count_value
);
	import ldpt_pkg::*;

	// Count cycles per interval at the 1MHz reference, minus one
	function automatic logic [31:0] ldpt_terminal(input ldpt_mode_e m);
		logic [31:0] t;
		t = LDPT_COUNT_MAX;
		case (m)
			LDPT_TICK_100: t = 32'(LDPT_REF_HZ / 100 - 1);
			LDPT_TICK_200: t = 32'(LDPT_REF_HZ / 200 - 1);
			LDPT_TICK_500: t = 32'(LDPT_REF_HZ / 500 - 1);
			LDPT_TICK_1K:  t = 32'(LDPT_REF_HZ / 1000 - 1);
			LDPT_TICK_2K:  t = 32'(LDPT_REF_HZ / 2000 - 1);
			LDPT_TICK_5K:  t = 32'(LDPT_REF_HZ / 5000 - 1);
			LDPT_TICK_10K: t = 32'(LDPT_REF_HZ / 10000 - 1);
			default:       t = LDPT_COUNT_MAX;
		endcase
		return t;
	endfunction

	// Byte lane select for a count address
	function automatic logic [3:0] ldpt_lane(input logic [2:0] a);
		logic [3:0] l;
		l = 4'h0;
		if (a <= LDPT_ADDR_BYTE3)
			l = 4'h1 << a[1:0];
		return l;
	endfunction

	logic [31:0] count;
	logic [31:0] snapshot;
	ldpt_ctrl_s  ctrl;
	logic [7:0]  next_rdata;

	wire logic        fast_rise;
	wire logic        slow_rise;
	wire logic        fast_tick;
	wire logic        count_tick;
	wire logic [31:0] terminal;
	wire logic        at_terminal;
	wire logic        event_hit;
	wire logic [3:0]  wr_lane;
	wire logic [3:0]  rd_lane;
	wire logic        wr_ctrl;
	wire logic        rd_low;
	wire logic [31:0] loaded;

	ldpt_sync u_fast_sync
	(
		.clk  (clk),
		.rst  (rst),
		.pin  (fast_source_clock),
		.rise (fast_rise)
	);

	ldpt_sync u_slow_sync
	(
		.clk  (clk),
		.rst  (rst),
		.pin  (slow_source_clock),
		.rise (slow_rise)
	);

	ldpt_prediv u_prediv
	(
		.clk     (clk),
		.rst     (rst),
		.edge_in (fast_rise),
		.tick    (fast_tick)
	);

	assign count_tick = ctrl.csel ? slow_rise : fast_tick;

	assign terminal    = ldpt_terminal(ctrl.mode);
	assign at_terminal = (count == terminal);
	assign event_hit   = ctrl.run & count_tick & at_terminal;

	assign wr_lane = req.wr ? ldpt_lane(req.addr) : 4'h0;
	assign rd_lane = req.rd ? ldpt_lane(req.addr) : 4'h0;
	assign wr_ctrl = req.wr & (req.addr == LDPT_ADDR_CTRL);
	assign rd_low  = req.rd & (req.addr == LDPT_ADDR_BYTE0);

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_lane
			assign loaded[g*8 +: 8] = wr_lane[g] ? req.wdata : count[g*8 +: 8];
		end
	endgenerate

	always_ff @(posedge clk or posedge por)
	begin
		if (por)
			count <= LDPT_COUNT_ZERO;
		else if (|wr_lane)
			count <= loaded;
		else if (ctrl.run & count_tick)
			count <= at_terminal ? LDPT_COUNT_ZERO : 32'(count + LDPT_COUNT_ONE);
	end

	always_ff @(posedge clk or posedge por)
	begin
		if (por)
			snapshot <= LDPT_COUNT_ZERO;
		else if (rd_low)
			snapshot <= count;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl.run  <= 1'b0;
			ctrl.mode <= LDPT_ELAPSED;
			ctrl.csel <= 1'b0;
			ctrl.flag <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
			begin
				ctrl.run  <= req.wdata[LDPT_BIT_RUN];
				ctrl.mode <= ldpt_mode_e'(req.wdata[LDPT_BIT_MODE +: 3]);
				ctrl.csel <= req.wdata[LDPT_BIT_CSEL];
			end
			if (event_hit)
				ctrl.flag <= 1'b1;
			else if (wr_ctrl & ~req.wdata[LDPT_BIT_FLAG])
				ctrl.flag <= 1'b0;
		end
	end

	// low read returns newly captured byte
	always_comb
	begin
		next_rdata = LDPT_BYTE_ZERO;
		if (rd_low)
			next_rdata = count[7:0];
		else if (|rd_lane)
			next_rdata = snapshot[req.addr[1:0]*8 +: 8];
		else if (req.rd & (req.addr == LDPT_ADDR_CTRL))
			next_rdata = {2'b00, ctrl};
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata <= LDPT_BYTE_ZERO;
		else if (req.rd)
			rdata <= next_rdata;
	end

	assign irq = ctrl.flag;

	always_ff @(posedge clk or posedge por)
	begin
		if (por)
			count_value <= LDPT_COUNT_ZERO;
		else
			count_value <= count;
	end
endmodule
